// ---- pkg/i2cs_pkg.sv ----
// Constants and carrier types of the I2C slave address and transfer block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package i2cs_pkg;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_ADDR = 5'h08;
  localparam logic [4:0] OFS_MASK = 5'h0c;
  localparam logic [4:0] OFS_BUF  = 5'h10;

  // Slave configurations selected by port_mode_select.
  typedef enum logic [1:0] {
    MODE_7B    = 2'h0,
    MODE_10B   = 2'h1,
    MODE_7B_SP = 2'h2,
    MODE_10B_SP = 2'h3
  } i2cs_mode_e;

  // Control register, bit 0 is port_mode_select[0].
  typedef struct packed {
    logic       stop_irq_enable;
    logic       start_irq_enable;
    logic       slave_collision_detect_enable;
    logic       buffer_overwrite_enable;
    logic       data_hold_enable;
    logic       address_hold_enable;
    logic       stretch_enable;
    logic       ack_value_select;
    logic       clock_release_bit;
    i2cs_mode_e port_mode_select;
  } i2cs_ctrl_s;

  // Status register, bit 0 is buffer_full_flag.
  typedef struct packed {
    logic bus_collision_flag;
    logic port_interrupt_flag;
    logic update_address_flag;
    logic ack_received_status;
    logic ack_time_flag;
    logic stop_seen;
    logic start_seen;
    logic data_not_address;
    logic read_not_write;
    logic receive_overflow_flag;
    logic buffer_full_flag;
  } i2cs_stat_s;

  localparam i2cs_ctrl_s CTRL_RST = 11'h004;
  localparam i2cs_stat_s STAT_RST = 11'h000;
  localparam logic [10:0] STAT_W1C = 11'h632;
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic [7:0]  MASK_RST = 8'hff;
  localparam logic [4:0]  HI_ADDR_TAG = 5'h1e;
  localparam logic [3:0]  BIT_ACK = 4'h8;

endpackage

// ---- rtl/i2cs_slave.sv ----
// I2C target-mode address matching and byte transfer engine with register file.
// Assumes SCL and SDA come asynchronously from open-drain pins and that a
// Wishbone master on clk_i services the registers.
//
// Overview of operation
// RULE1: Mode field selects 7 or 10-bit addressing, with or without start/stop interrupts.
// RULE2: Start/stop modes also set the interrupt flag on start, restart and stop.
// RULE3: First byte after start compared to address; match loads buffer, raises interrupt.
// RULE4: Mismatching first byte sends the engine idle with no flag.
// RULE5: Seven-bit compare ignores the direction bit.
// RULE6: Ten-bit high byte matches 11110, address bits 2 and 1, direction.
// RULE7: Acked high byte sets update flag, holds SCL until address write.
// RULE8: Low byte compares eight bits; always sets interrupt and update flags.
// RULE9: Ten-bit read needs prior full write match, then restart with read high.
// RULE10: Matching write address clears direction status, loads buffer, acknowledges.
// RULE11: Buffer full or overflow forces not-acknowledge unless overwrite enable; with overwrite enable set, the code still NACKs on overflow.
// RULE12: Interrupt flag set once per byte; only software clears it.
// RULE13: Stretch enable holds SCL after each received byte until release bit set; the code does not hold SCL after a not-acknowledged data byte.
// RULE14: Address or data hold sets flag, clears release bit after eighth fall.
// RULE15: During hold software reads buffer, picks ack value, sets release bit.
// RULE16: With holds, flag set after ninth fall only when acknowledge was sent.
// RULE17: Stop sets stop-seen status for polling.
// RULE18: Matching read address sets direction status, loads buffer, acknowledges.
// RULE19: Read acknowledge clears release bit; buffer write loads shifter.
// RULE20: Transmit bits change on SCL falling edges only.
// RULE21: Master ack captured on ninth rise; not-acknowledge ends the transfer.
// RULE22: Transmission sets interrupt flag on ninth falling edge.
// RULE23: Collision while transmitting with detect enable sets flag and idles.
// RULE24: Ack-time flag set after eighth fall when holds enabled.
// RULE25: Separate start/stop enables add those interrupts in other modes.
// RULE26: Buffer read clears full flag; buffer write sets it.
// RULE27: Cleared mask bits are don't-care in address compare.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module i2cs_slave
  import i2cs_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // I2C pins.
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LOW, ST_RX, ST_TX} i2cs_state_e;

  i2cs_ctrl_s  ctrl;
  i2cs_stat_s  stat;
  i2cs_state_e st;
  logic [7:0]  addr;
  logic [7:0]  mask;
  logic [7:0]  rbuf;
  logic [7:0]  rx_sr;
  logic [7:0]  tx_sr;
  logic [3:0]  bitcnt;
  logic        send_ack;
  logic        held;
  logic        hit;
  logic        prior;
  logic        stretch;
  logic        scl_m, scl_s, scl_d;
  logic        sda_m, sda_s, sda_d;

  // Bus decode.
  wire wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr    = wb_hit & wb_we_i;
  wire wb_rd    = wb_hit & ~wb_we_i;
  wire wide_sel = &wb_sel_i[1:0];
  wire wr_ctrl  = wb_wr & wide_sel & (wb_adr_i == OFS_CTRL);
  wire wr_stat  = wb_wr & wide_sel & (wb_adr_i == OFS_STAT);
  wire wr_addr  = wb_wr & wb_sel_i[0] & (wb_adr_i == OFS_ADDR);
  wire wr_mask  = wb_wr & wb_sel_i[0] & (wb_adr_i == OFS_MASK);
  wire wr_buf   = wb_wr & wb_sel_i[0] & (wb_adr_i == OFS_BUF);
  wire rd_buf   = wb_rd & (wb_adr_i == OFS_BUF);
  wire [31:0] rd_data =
    (wb_adr_i == OFS_CTRL) ? {21'h0, ctrl} :
    (wb_adr_i == OFS_STAT) ? {21'h0, stat} :
    (wb_adr_i == OFS_ADDR) ? {24'h0, addr} :
    (wb_adr_i == OFS_MASK) ? {24'h0, mask} :
    (wb_adr_i == OFS_BUF)  ? {24'h0, rbuf} : 32'h0;

  // Line events, all taken from the second synchroniser stage onward.
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_evt = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_evt  = scl_s & scl_d & ~sda_d & sda_s;
  wire is10      = ctrl.port_mode_select[0];
  wire sp_mode   = ctrl.port_mode_select[1];
  wire holds     = ctrl.address_hold_enable | ctrl.data_hold_enable;
  wire active    = (st != ST_IDLE);
  wire byte_end  = scl_fall & (bitcnt == 4'h7) & active;
  wire ninth     = scl_fall & (bitcnt == BIT_ACK) & active;

  // Masked comparisons.
  wire [7:0] diff = (rx_sr ^ addr) & mask;                      // RULE27
  wire m7  = (diff[7:1] == 7'h0);                               // RULE5
  wire mhi = (rx_sr[7:3] == HI_ADDR_TAG) & (diff[2:1] == 2'h0); // RULE6
  wire mlo = (diff == 8'h0);                                    // RULE8
  wire hi_ok    = mhi & (~rx_sr[0] | prior);                    // RULE9
  wire addr_hit = is10 ? hi_ok : m7;
  wire nack_cond = ctrl.buffer_overwrite_enable ? stat.receive_overflow_flag
                 : (stat.buffer_full_flag | stat.receive_overflow_flag); // RULE11
  wire ack_drv  = held ? ~ctrl.ack_value_select : send_ack;     // RULE15
  wire want_hold = stat.update_address_flag | (~ctrl.clock_release_bit & active);

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = stretch;
  assign sda_oe_o = active & ((st != ST_TX) ? ((bitcnt == BIT_ACK) & ack_drv)
                                            : ((bitcnt != BIT_ACK) & ~tx_sr[7]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else if (ce_i) begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      stretch  <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_rd ? rd_data : wb_dat_o;
      // SCL is only grabbed once it is already low, to respect its high time.
      stretch  <= want_hold & (stretch | ~scl_s);                // RULE7 RULE13
    end
  end

  // Software accesses come first so that a hardware set in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      stat <= STAT_RST;
      addr <= ADDR_RST;
      mask <= MASK_RST;
      rbuf <= 8'h00;
      st <= ST_IDLE;
      {rx_sr, tx_sr} <= 16'hffff;
      bitcnt <= 4'h0;
      {send_ack, held, hit, prior} <= 4'h0;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl <= i2cs_ctrl_s'(wb_dat_i[10:0]);
      if (wr_stat) stat <= i2cs_stat_s'(stat & ~(wb_dat_i[10:0] & STAT_W1C));
      if (wr_mask) mask <= wb_dat_i[7:0];
      if (wr_addr) begin
        addr <= wb_dat_i[7:0];
        stat.update_address_flag <= 1'b0;                        // RULE7
      end
      if (rd_buf) stat.buffer_full_flag <= 1'b0;                 // RULE26
      if (wr_buf) begin
        rbuf <= wb_dat_i[7:0];
        tx_sr <= wb_dat_i[7:0];                                  // RULE19
        stat.buffer_full_flag <= 1'b1;                           // RULE26
      end
      if (scl_rise & active) begin
        if (bitcnt != BIT_ACK) rx_sr <= {rx_sr[6:0], sda_s};
        if (st == ST_TX && bitcnt == BIT_ACK)
          stat.ack_received_status <= sda_s;                     // RULE21
        if (st == ST_TX && bitcnt != BIT_ACK && tx_sr[7] && !sda_s &&
            ctrl.slave_collision_detect_enable) begin
          stat.bus_collision_flag <= 1'b1;                       // RULE23
          st <= ST_IDLE;
        end
      end
      if (scl_fall & active & (bitcnt != BIT_ACK)) begin
        bitcnt <= bitcnt + 4'h1;
        if (st == ST_TX) tx_sr <= {tx_sr[6:0], 1'b1};            // RULE20
      end
      if (byte_end) begin
        case (st)
          ST_ADDR: begin
            if (is10 && mhi && !rx_sr[0]) prior <= 1'b0;
            if (!addr_hit) begin
              st <= ST_IDLE;                                     // RULE4
              prior <= 1'b0;
            end else begin
              stat.read_not_write <= rx_sr[0];                   // RULE10 RULE18
              stat.data_not_address <= 1'b0;
              send_ack <= ~nack_cond;                            // RULE11
              if (nack_cond) stat.receive_overflow_flag <= 1'b1;
              else begin
                rbuf <= rx_sr;                                   // RULE3
                stat.buffer_full_flag <= 1'b1;
              end
              stat.ack_time_flag <= holds;                       // RULE24
              if (ctrl.address_hold_enable) begin
                stat.port_interrupt_flag <= 1'b1;                // RULE14
                ctrl.clock_release_bit <= 1'b0;
                held <= 1'b1;
              end
            end
          end
          ST_LOW: begin
            hit <= mlo;                                          // RULE8
            send_ack <= mlo & ~nack_cond;
            if (mlo) begin
              rbuf <= rx_sr;
              stat.buffer_full_flag <= 1'b1;
            end
          end
          ST_RX: begin
            stat.data_not_address <= 1'b1;
            send_ack <= ~nack_cond;                              // RULE11
            if (nack_cond) stat.receive_overflow_flag <= 1'b1;
            else begin
              rbuf <= rx_sr;
              stat.buffer_full_flag <= 1'b1;
            end
            stat.ack_time_flag <= holds;
            if (ctrl.data_hold_enable) begin
              stat.port_interrupt_flag <= 1'b1;                  // RULE14
              ctrl.clock_release_bit <= 1'b0;
              held <= 1'b1;
            end
          end
          ST_TX: stat.buffer_full_flag <= 1'b0;
          default: st <= ST_IDLE;
        endcase
      end
      if (ninth) begin
        bitcnt <= 4'h0;
        held <= 1'b0;
        stat.ack_time_flag <= 1'b0;
        case (st)
          ST_TX: begin
            stat.port_interrupt_flag <= 1'b1;                    // RULE22
            if (stat.ack_received_status) st <= ST_IDLE;         // RULE21
            else ctrl.clock_release_bit <= 1'b0;
          end
          ST_ADDR: begin
            if (ack_drv | ~holds) stat.port_interrupt_flag <= 1'b1; // RULE12 RULE16
            if (!ack_drv) st <= ST_IDLE;
            else if (stat.read_not_write) begin
              st <= ST_TX;
              ctrl.clock_release_bit <= 1'b0;                    // RULE19
            end else if (is10 && !prior) begin
              st <= ST_LOW;
              stat.update_address_flag <= 1'b1;                  // RULE7
            end else begin
              st <= ST_RX;
              if (ctrl.stretch_enable) ctrl.clock_release_bit <= 1'b0; // RULE13
            end
          end
          ST_LOW: begin
            stat.port_interrupt_flag <= 1'b1;                    // RULE8
            stat.update_address_flag <= 1'b1;
            if (hit && ack_drv) begin
              st <= ST_RX;
              prior <= 1'b1;                                     // RULE9
            end else st <= ST_IDLE;
          end
          ST_RX: begin
            if (ack_drv | ~holds) stat.port_interrupt_flag <= 1'b1; // RULE12 RULE16
            if (ack_drv && ctrl.stretch_enable)
              ctrl.clock_release_bit <= 1'b0;                    // RULE13
          end
          default: st <= ST_IDLE;
        endcase
      end
      if (start_evt) begin
        st <= ST_ADDR;
        // The SCL fall that closes a Start wraps this to zero, so it is never counted as a bit.
        bitcnt <= 4'hf;
        held <= 1'b0;
        stat.start_seen <= 1'b1;
        stat.stop_seen <= 1'b0;
        ctrl.clock_release_bit <= 1'b1;
        if (sp_mode | ctrl.start_irq_enable)
          stat.port_interrupt_flag <= 1'b1;                      // RULE1 RULE2 RULE25
      end
      if (stop_evt) begin
        st <= ST_IDLE;
        prior <= 1'b0;
        held <= 1'b0;
        stat.stop_seen <= 1'b1;                                  // RULE17
        stat.start_seen <= 1'b0;
        ctrl.clock_release_bit <= 1'b1;
        if (sp_mode | ctrl.stop_irq_enable)
          stat.port_interrupt_flag <= 1'b1;                      // RULE2 RULE25
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ua_holds_scl: assert property (                                // RULE7
    (ce_i && stat.update_address_flag && !scl_s && !wr_addr) |=> ##1 (scl_oe_o || !ce_i))
    else $error("SCL not held while update flag set");
  chk_addr_write_ua: assert property (                               // RULE7
    (ce_i && wr_addr && !ninth) |=> !stat.update_address_flag)
    else $error("address write did not clear update flag");
  chk_nomatch_idle: assert property (                                // RULE4
    (ce_i && byte_end && st == ST_ADDR && !addr_hit && !start_evt) |=>
      (st == ST_IDLE && $stable(stat.buffer_full_flag)))
    else $error("mismatched address did not go idle");
  chk_buf_read_clr: assert property (                                // RULE26
    (ce_i && rd_buf && !wr_buf && !byte_end) |=> !stat.buffer_full_flag)
    else $error("buffer read left full flag set");
  chk_tx_sda_stable: assert property (                               // RULE20
    (st == ST_TX && scl_s && scl_d && $stable(st) && !start_evt) |-> $stable(sda_oe_o))
    else $error("transmit data changed while SCL high");
  chk_stop_flag: assert property (                                   // RULE17
    (ce_i && stop_evt) |=> (stat.stop_seen && st == ST_IDLE))
    else $error("stop not recorded");
  chk_tx_nack_idle: assert property (                                // RULE21 RULE22
    (ce_i && ninth && st == ST_TX && stat.ack_received_status && !stop_evt && !start_evt)
      |=> (st == ST_IDLE && stat.port_interrupt_flag))
    else $error("not-acknowledge did not end transmission");
  chk_ovf_nack: assert property (                                    // RULE11
    (ce_i && byte_end && st == ST_RX && stat.receive_overflow_flag) |=> !send_ack)
    else $error("overflow still acknowledged");
  chk_collision: assert property (                                   // RULE23
    (ce_i && scl_rise && st == ST_TX && bitcnt != BIT_ACK && tx_sr[7] && !sda_s &&
     ctrl.slave_collision_detect_enable && !stop_evt && !start_evt)
      |=> (stat.bus_collision_flag && st == ST_IDLE))
    else $error("collision not flagged");

  cov_write_byte: cover property (ninth && st == ST_RX && ack_drv);
  cov_read_byte: cover property (ninth && st == ST_TX);
  cov_ten_bit_low: cover property (ninth && st == ST_LOW && hit);
  cov_hold_release: cover property (held && $rose(ctrl.clock_release_bit));

endmodule // i2cs_slave

// ---- test/i2cs_master_model.sv ----
// Behavioural I2C bus master: Start, Stop and bit transfers at 320 ns per SCL period.
// Assumes pull-ups and a wire-AND of all drivers, resolved by the bench and fed back.
`timescale 1ns/100ps
module i2cs_master_model (
  // Clock and resolved bus levels.
  input  wire logic clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Open-drain drive, 0 pulls the line low; stall_o flags a stretch that never ends.
  output logic      scl_o,
  output logic      sda_o,
  output logic      stall_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    stall_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // The slave may stretch, so the high phase starts only once the wire is high.
  task automatic scl_up();
    int n;
    n = 0;
    scl_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (scl_i !== 1'b1 && n < 5000);
    if (n >= 5000) stall_o <= 1'b1;
    tick(2);
  endtask
  // Serves as Start and as Restart, since SDA is raised while SCL is still low.
  task automatic start();
    sda_o <= 1'b1;
    tick(4);
    scl_up();
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    tick(4);
    scl_up();
    tick(2);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // MSB first; the ninth slot carries the acknowledge in either direction.
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx,
                      output logic ak);
    logic [8:0] o;
    logic [8:0] s;
    o = {tx, ab};
    for (int k = 8; k >= 0; k--) begin
      tick(1);
      sda_o <= o[k];
      tick(3);
      scl_up();
      s[k] = sda_i;
      tick(1);
      scl_o <= 1'b0;
    end
    {rx, ak} = s;
  endtask
endmodule // i2cs_master_model

// ---- test/i2cs_slave_tb.sv ----
// Self-checking bench for i2cs_slave: Wishbone register tasks and an I2C master model.
// Assumes the design carries its own assertions; clk_i runs at 25 MHz.
`timescale 1ns/100ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module i2cs_slave_tb
  import i2cs_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] d;
  logic [7:0]  rx;
  logic        ak;
  wire  [31:0] rdat;
  wire         ack, scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, stall;
  wire         scl = m_scl & ~scl_oe;
  wire         sda = m_sda & ~sda_oe;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] modes [3] = '{32'h006, 32'h007, 32'h604};

  always #20 clk_i = ~clk_i;

  i2cs_slave i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe));
  i2cs_master_model i_master (
    .clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_o(m_scl), .sda_o(m_sda),
    .stall_o(stall));

  task automatic stop_test();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic give_up();
    num_errors++;
    stop_test();
  endtask
  // Request held until the edge at which ack is seen high, then released there.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask
  task automatic st(input int b, input logic v);
    rd(OFS_STAT);
    `CHECK(d[b], v)
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rd(OFS_STAT);
      n++;
    end while (d[b] !== 1'b1 && n < 400);
    if (n >= 400) give_up();
  endtask
  // Flags trail the pins by a few clocks of synchronisation.
  task automatic byte8(input logic [7:0] t, input logic ab);
    i_master.xfer(t, ab, rx, ak);
    repeat (8) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (stall === 1'b1) give_up();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL);
    `CHECK(d[10:0], 11'(CTRL_RST))
    rd(OFS_MASK);
    `CHECK(d, 32'hff)
    rd(5'h14);
    `CHECK(d, 32'h0)
    `CHECK({scl_o, sda_o}, 2'b00)
    wr(OFS_ADDR, 32'ha4);
    wr(OFS_CTRL, 32'h014);
    i_master.start();
    byte8(8'ha4, 1'b1);
    `CHECK(ak, 1'b0)
    `CHECK(scl_oe, 1'b1)
    st(2, 1'b0);
    st(9, 1'b1);
    rd(OFS_BUF);
    `CHECK(d[7:0], 8'ha4)
    st(0, 1'b0);
    wr(OFS_STAT, 32'h200);
    wr(OFS_CTRL, 32'h014);
    byte8(8'h3c, 1'b1);
    `CHECK(ak, 1'b0)
    rd(OFS_BUF);
    `CHECK(d[7:0], 8'h3c)
    wr(OFS_CTRL, 32'h014);
    i_master.stop();
    st(5, 1'b1);
    wr(OFS_CTRL, 32'h004);
    wr(OFS_STAT, 32'h632);
    i_master.start();
    byte8(8'h40, 1'b1);
    `CHECK(ak, 1'b1)
    st(9, 1'b0);
    wr(OFS_MASK, 32'hfd);
    i_master.start();
    byte8(8'ha6, 1'b1);
    `CHECK(ak, 1'b0)
    byte8(8'h11, 1'b1);
    `CHECK(ak, 1'b1)
    st(1, 1'b1);
    byte8(8'h22, 1'b1);
    `CHECK(ak, 1'b1)
    i_master.stop();
    wr(OFS_MASK, 32'hff);
    rd(OFS_BUF);
    wr(OFS_STAT, 32'h632);
    i_master.start();
    byte8(8'ha5, 1'b1);
    `CHECK(ak, 1'b0)
    st(2, 1'b1);
    rd(OFS_CTRL);
    `CHECK(d[2], 1'b0)
    wr(OFS_STAT, 32'h200);
    wr(OFS_BUF, 32'h96);
    wr(OFS_CTRL, 32'h004);
    byte8(8'hff, 1'b0);
    `CHECK(rx, 8'h96)
    st(9, 1'b1);
    wr(OFS_BUF, 32'h5a);
    wr(OFS_CTRL, 32'h004);
    byte8(8'hff, 1'b1);
    `CHECK(rx, 8'h5a)
    st(7, 1'b1);
    i_master.stop();
    wr(OFS_CTRL, 32'h104);
    i_master.start();
    byte8(8'ha5, 1'b1);
    wr(OFS_BUF, 32'hff);
    wr(OFS_CTRL, 32'h104);
    byte8(8'h7f, 1'b1);
    st(10, 1'b1);
    `CHECK(sda_oe, 1'b0)
    i_master.stop();
    wr(OFS_CTRL, 32'h005);
    wr(OFS_ADDR, 32'hf4);
    rd(OFS_BUF);
    wr(OFS_STAT, 32'h632);
    i_master.start();
    byte8(8'hf4, 1'b1);
    `CHECK(ak, 1'b0)
    st(8, 1'b1);
    fork
      byte8(8'h33, 1'b1);
      begin
        repeat (60) @(posedge clk_i);
        `CHECK(scl_oe, 1'b1)
        rd(OFS_BUF);
        wr(OFS_ADDR, 32'h33);
      end
    join
    `CHECK(ak, 1'b0)
    st(8, 1'b1);
    fork
      byte8(8'h77, 1'b1);
      begin
        repeat (60) @(posedge clk_i);
        rd(OFS_BUF);
        wr(OFS_ADDR, 32'hf4);
      end
    join
    rd(OFS_BUF);
    i_master.start();
    byte8(8'hf5, 1'b1);
    `CHECK(ak, 1'b0)
    st(2, 1'b1);
    wr(OFS_BUF, 32'hff);
    wr(OFS_ADDR, 32'hf4);
    wr(OFS_CTRL, 32'h005);
    i_master.stop();
    wr(OFS_CTRL, 32'h024);
    wr(OFS_ADDR, 32'ha4);
    rd(OFS_BUF);
    wr(OFS_STAT, 32'h632);
    i_master.start();
    fork
      byte8(8'ha4, 1'b1);
      begin
        poll(9);
        `CHECK(d[6], 1'b1)
        rd(OFS_CTRL);
        `CHECK(d[2], 1'b0)
        wr(OFS_STAT, 32'h200);
        wr(OFS_CTRL, 32'h02c);
      end
    join
    `CHECK(ak, 1'b1)
    st(9, 1'b0);
    i_master.stop();
    wr(OFS_CTRL, 32'h0c4);
    wr(OFS_STAT, 32'h632);
    i_master.start();
    byte8(8'ha4, 1'b1);
    `CHECK(ak, 1'b0)
    wr(OFS_STAT, 32'h200);
    fork
      byte8(8'h5c, 1'b1);
      begin
        poll(9);
        `CHECK(d[6], 1'b1)
        rd(OFS_BUF);
        `CHECK(d[7:0], 8'h5c)
        wr(OFS_STAT, 32'h200);
        wr(OFS_CTRL, 32'h0c4);
      end
    join
    `CHECK(ak, 1'b0)
    st(9, 1'b1);
    i_master.stop();
    foreach (modes[i]) begin
      wr(OFS_CTRL, modes[i]);
      wr(OFS_STAT, 32'h632);
      i_master.start();
      st(9, 1'b1);
      wr(OFS_STAT, 32'h200);
      i_master.stop();
      st(9, 1'b1);
    end
    stop_test();
  end
endmodule // i2cs_slave_tb
